// ==== hw/lbc_top.sv ====
// Local bus controller: bus cycles, hold arbitration, control block
// Contract
// - Drive address latch strobe plus active-low read and write strobes.
// - No dedicated memory-versus-I/O output; status lines serve instead.
// - Transceiver enable low during memory, I/O and interrupt ack cycles.
// - Transceiver direction high for writes, low for reads.
// - Bus request is asynchronous and synchronised before use.
// - On grant, float strobes, status, lock, address, refresh, transceiver.
// - Bus request ranks below refresh, above everything else.
// - Finish any cycle in progress before granting.
// - Postpone grant until a locked sequence has finished.
// - Pending refresh while granted drops the grant output.
// - Retake the bus only after the other master drops its request.
// - In reset drive enable, read, write high one clock, then float.
// - In reset drive status all high and lock high, then float.
// - In reset float address, refresh, direction; latch strobe, grant low.
// - Sample queue-status, float-all and enhanced straps during reset.
// - Control block accesses run a bus cycle but ignore data and ready.
// - Control block on 256-byte boundary from low relocation bits 11:0.
// - Relocation bit 12 picks memory or I/O space for the block.
// - Relocation register resets to 20FFH: block at FF00H in I/O.
// - Relocation holds slave-mode bit; registers always read and write.
`timescale 1ns/1ns
module lbc_top #(
	parameter int ADDR_W = 20,
	parameter int DATA_W = 8
) (
	// Clock and control
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              ce,
	// Internal cycle requests
	input  wire logic              cpuReqValid,
	input  wire lbc_pkg::lbc_req_t cpuReq,
	input  wire logic              refreshReq,
	output logic                   cpuDone,
	output logic      [DATA_W-1:0] cpuReadData,
	output logic                   refreshDone,
	// Arbitration
	input  wire logic              holdRequest,
	output logic                   busGrantOut,
	// Ready and data inputs
	input  wire logic              syncReadyInput,
	input  wire logic              asyncReadyInput,
	input  wire logic [DATA_W-1:0] adIn,
	// Bus pins and their enables
	output lbc_pkg::lbc_pins_t     pins,
	output lbc_pkg::lbc_oe_t       pinsOe,
	// Straps
	input  wire logic              readStrobeQueueStrap,
	input  wire logic              upperMemorySelect,
	input  wire logic              lowerMemorySelect,
	input  wire logic              testInput,
	// Modes
	output logic                   queueStatusMode,
	output logic                   allPinsFloatMode,
	output logic                   enhancedMode,
	output logic                   interruptSlaveMode,
	output logic                   controlBlockInMemory
);

	if (ADDR_W != 20 || DATA_W != 8)
		$error("lbc_top serves a 20-bit address and 8-bit data bus only");

	// ****************************************************
	// Declarations
	// ****************************************************
	lbc_pkg::lbc_state_t state_r;
	lbc_pkg::lbc_state_t stateNxt;
	lbc_pkg::lbc_req_t   cur_r;
	lbc_pkg::lbc_req_t   sel;
	lbc_pkg::lbc_req_t   cyc;
	logic                isRefresh_r;
	logic                cbHit_r;
	logic                refreshPend_r;
	logic                lockSeq_r;
	logic [15:0]         reloc_r;
	logic [7:0]          refreshRow_r;
	logic                rstSeen_r;
	logic                holdSync;
	logic                asyncReadySync;
	logic                startCycle;
	logic                startRefresh;
	logic                ready;
	logic                cycWrite;
	logic                cycHalt;
	logic                selHit;
	logic                endCycle;
	logic [7:0]          cbReadData;

	// ****************************************************
	// Synchronisers and straps
	// ****************************************************
	lbc_sync #(
		.WIDTH  (2),
		.STAGES (lbc_pkg::SYNC_STAGES)
	) uSync (
		.clock   (clock),
		.rst_n   (rst_n),
		.ce      (ce),
		.asyncIn ({holdRequest, asyncReadyInput}),
		.syncOut ({holdSync, asyncReadySync})
	);

	lbc_strap uStrap (
		.clock                (clock),
		.rst_n                (rst_n),
		.ce                   (ce),
		.readStrobeQueueStrap (readStrobeQueueStrap),
		.upperMemorySelect    (upperMemorySelect),
		.lowerMemorySelect    (lowerMemorySelect),
		.testInput            (testInput),
		.queueStatusMode      (queueStatusMode),
		.allPinsFloatMode     (allPinsFloatMode),
		.enhancedMode         (enhancedMode)
	);

	// ****************************************************
	// Request selection and control block decode
	// ****************************************************
	always_comb
	begin
		sel = cpuReq;
		if (refreshPend_r)
		begin
			sel.kind   = lbc_pkg::KIND_MEMRD;
			sel.addr   = {12'h000, refreshRow_r};
			sel.wdata  = 8'h00;
			sel.locked = 1'b0;
		end
	end

	// Block base is the low relocation bits on a 256-byte boundary
	assign selHit = !refreshPend_r
		&& sel.kind != lbc_pkg::KIND_IACK
		&& sel.kind != lbc_pkg::KIND_HALT
		&& sel.kind[2] == reloc_r[lbc_pkg::RELOC_MEM_BIT]
		&& sel.addr[19:8] == reloc_r[lbc_pkg::BASE_W-1:0];

	assign cyc = (state_r == lbc_pkg::ST_IDLE) ? sel : cur_r;
	assign cycWrite = cyc.kind == lbc_pkg::KIND_MEMWR
		|| cyc.kind == lbc_pkg::KIND_IOWR;
	assign cycHalt = cyc.kind == lbc_pkg::KIND_HALT;

	// Refresh first, then hold, then the processor
	assign startRefresh = state_r == lbc_pkg::ST_IDLE && refreshPend_r;
	// A locked sequence keeps its own requests ahead of a pending hold
	assign startCycle = startRefresh || (state_r == lbc_pkg::ST_IDLE
		&& (!holdSync || lockSeq_r) && cpuReqValid);

	// Control block cycles never wait on external ready
	assign ready = cbHit_r || syncReadyInput || asyncReadySync;
	assign endCycle = stateNxt == lbc_pkg::ST_T4;

	// ****************************************************
	// Bus state machine
	// ****************************************************
	always_comb
	begin
		stateNxt = state_r;
		case (state_r)
			lbc_pkg::ST_IDLE:
				if (startCycle)
					stateNxt = lbc_pkg::ST_T1;
				else if (holdSync && !lockSeq_r)
					stateNxt = lbc_pkg::ST_HOLD;
			lbc_pkg::ST_T1:
				stateNxt = lbc_pkg::ST_T2;
			lbc_pkg::ST_T2:
				stateNxt = lbc_pkg::ST_T3;
			lbc_pkg::ST_T3, lbc_pkg::ST_TW:
				stateNxt = ready ? lbc_pkg::ST_T4 : lbc_pkg::ST_TW;
			lbc_pkg::ST_T4:
				stateNxt = lbc_pkg::ST_IDLE;
			lbc_pkg::ST_HOLD:
				if (!holdSync)
					stateNxt = lbc_pkg::ST_IDLE;
				else if (refreshPend_r)
					stateNxt = lbc_pkg::ST_RECLAIM;
			lbc_pkg::ST_RECLAIM:
				if (!holdSync)
					stateNxt = lbc_pkg::ST_IDLE;
			default:
				stateNxt = lbc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			state_r <= lbc_pkg::ST_IDLE;
		else if (ce)
			state_r <= stateNxt;
	end

	// ****************************************************
	// Cycle capture, refresh and lock tracking
	// ****************************************************
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			cur_r       <= '0;
			isRefresh_r <= 1'b0;
			cbHit_r     <= 1'b0;
		end
		else if (ce && startCycle)
		begin
			cur_r       <= sel;
			isRefresh_r <= refreshPend_r;
			cbHit_r     <= selHit;
		end
	end

	// A new refresh request wins over the clear of an old one
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			refreshPend_r <= 1'b0;
			refreshRow_r  <= lbc_pkg::REFRESH_ROW0;
		end
		else if (ce)
		begin
			refreshPend_r <= (refreshPend_r && !startRefresh) || refreshReq;
			if (endCycle && isRefresh_r && state_r != lbc_pkg::ST_T4)
				refreshRow_r <= refreshRow_r + 8'h01;
		end
	end

	// Sequence stays locked until an unlocked processor cycle completes; refresh cycles do not end it
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			lockSeq_r <= 1'b0;
		else if (ce)
		begin
			if (startCycle && !refreshPend_r && sel.locked)
				lockSeq_r <= 1'b1;
			else if (endCycle && !isRefresh_r && !cur_r.locked
				&& state_r != lbc_pkg::ST_T4)
				lockSeq_r <= 1'b0;
		end
	end

	// ****************************************************
	// Relocation register
	// ****************************************************
	always_comb
	begin
		case (cur_r.addr[7:0])
			lbc_pkg::RELOC_OFS_LO: cbReadData = reloc_r[7:0];
			lbc_pkg::RELOC_OFS_HI: cbReadData = reloc_r[15:8];
			default:               cbReadData = 8'h00;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			reloc_r <= lbc_pkg::RELOC_RESET;
		else if (ce && endCycle && cbHit_r && state_r != lbc_pkg::ST_T4
			&& (cur_r.kind == lbc_pkg::KIND_MEMWR
			|| cur_r.kind == lbc_pkg::KIND_IOWR))
		begin
			if (cur_r.addr[7:0] == lbc_pkg::RELOC_OFS_LO)
				reloc_r[7:0] <= cur_r.wdata;
			else if (cur_r.addr[7:0] == lbc_pkg::RELOC_OFS_HI)
				reloc_r[15:8] <= cur_r.wdata;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			interruptSlaveMode   <= lbc_pkg::RELOC_RESET[lbc_pkg::RELOC_SLV_BIT];
			controlBlockInMemory <= lbc_pkg::RELOC_RESET[lbc_pkg::RELOC_MEM_BIT];
		end
		else if (ce)
		begin
			interruptSlaveMode   <= reloc_r[lbc_pkg::RELOC_SLV_BIT];
			controlBlockInMemory <= reloc_r[lbc_pkg::RELOC_MEM_BIT];
		end
	end

	// ****************************************************
	// Answers to the internal requesters
	// ****************************************************
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			cpuDone     <= 1'b0;
			refreshDone <= 1'b0;
			cpuReadData <= 8'h00;
		end
		else if (ce)
		begin
			cpuDone     <= endCycle && !isRefresh_r
				&& state_r != lbc_pkg::ST_T4;
			refreshDone <= endCycle && isRefresh_r
				&& state_r != lbc_pkg::ST_T4;
			if (endCycle && state_r != lbc_pkg::ST_T4)
				cpuReadData <= cbHit_r ? cbReadData : adIn;
		end
	end

	// ****************************************************
	// Bus pins
	// ****************************************************
	// Memory and I/O are told apart only by the status lines
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			rstSeen_r   <= 1'b1;
			busGrantOut <= 1'b0;
			pins        <= '1;
			pins.ale    <= 1'b0;
			pins.busStatusLines <= lbc_pkg::STAT_PASSIVE;
			pinsOe      <= '0;
			pinsOe.strobes <= !rstSeen_r;
			pinsOe.status  <= !rstSeen_r;
			pinsOe.lock    <= !rstSeen_r;
		end
		else if (ce)
		begin
			rstSeen_r   <= 1'b0;
			busGrantOut <= stateNxt == lbc_pkg::ST_HOLD;
			pins.ale    <= stateNxt == lbc_pkg::ST_T1;
			case (stateNxt)
				lbc_pkg::ST_T1:
				begin
					pins.addrHigh             <= cyc.addr[19:8];
					pins.adOut                <= cyc.addr[7:0];
					pins.busStatusLines       <= cyc.kind;
					pins.transceiverDirection <= cycWrite;
					pins.refreshIndicator     <= !startRefresh;
					pins.lockN                <= !cyc.locked;
				end
				lbc_pkg::ST_T2:
				begin
					pins.adOut              <= cyc.wdata;
					pins.readN              <= cycWrite || cycHalt;
					pins.writeN             <= !cycWrite;
					pins.transceiverEnableN <= cycHalt;
				end
				lbc_pkg::ST_T3, lbc_pkg::ST_TW:
					pins.busStatusLines <= pins.busStatusLines;
				default:
				begin
					pins.readN              <= 1'b1;
					pins.writeN             <= 1'b1;
					pins.transceiverEnableN <= 1'b1;
					pins.busStatusLines     <= lbc_pkg::STAT_PASSIVE;
					pins.refreshIndicator   <= 1'b1;
					pins.lockN              <= !lockSeq_r;
				end
			endcase
			// Granted or float mode: every bus pin released
			if (stateNxt == lbc_pkg::ST_HOLD
				|| stateNxt == lbc_pkg::ST_RECLAIM || allPinsFloatMode)
				pinsOe <= '0;
			else
			begin
				pinsOe   <= '1;
				pinsOe.ad <= stateNxt == lbc_pkg::ST_T1
					|| (cycWrite && stateNxt != lbc_pkg::ST_IDLE);
			end
		end
	end

endmodule

// ==== shared/lbc_pkg.sv ====
// Shared constants and types for the local bus controller
package lbc_pkg;

	// ****************************************************
	// Control block and relocation register
	// ****************************************************
	localparam logic [7:0]  RELOC_OFS_LO  = 8'hfe;
	localparam logic [7:0]  RELOC_OFS_HI  = 8'hff;
	localparam logic [15:0] RELOC_RESET   = 16'h20ff;
	localparam int          RELOC_MEM_BIT = 12;
	localparam int          RELOC_SLV_BIT = 14;
	localparam int          BASE_W        = 12;
	localparam int          CB_OFS_W      = 8;

	// ****************************************************
	// Bus encodings and counts
	// ****************************************************
	localparam logic [2:0]  STAT_PASSIVE  = 3'h7;
	localparam int          SYNC_STAGES   = 2;
	localparam logic [7:0]  REFRESH_ROW0  = 8'h00;

	typedef enum logic [2:0] {
		KIND_IACK  = 3'b000,
		KIND_IORD  = 3'b001,
		KIND_IOWR  = 3'b010,
		KIND_HALT  = 3'b011,
		KIND_FETCH = 3'b100,
		KIND_MEMRD = 3'b101,
		KIND_MEMWR = 3'b110,
		KIND_NONE  = 3'b111
	} lbc_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_T1      = 3'b001,
		ST_T2      = 3'b010,
		ST_T3      = 3'b011,
		ST_TW      = 3'b100,
		ST_T4      = 3'b101,
		ST_HOLD    = 3'b110,
		ST_RECLAIM = 3'b111
	} lbc_state_t;

	typedef struct packed {
		lbc_kind_t   kind;
		logic [19:0] addr;
		logic [7:0]  wdata;
		logic        locked;
	} lbc_req_t;

	typedef struct packed {
		logic        ale;
		logic        readN;
		logic        writeN;
		logic        transceiverEnableN;
		logic        transceiverDirection;
		logic [2:0]  busStatusLines;
		logic        lockN;
		logic        refreshIndicator;
		logic [11:0] addrHigh;
		logic [7:0]  adOut;
	} lbc_pins_t;

	typedef struct packed {
		logic strobes;
		logic status;
		logic lock;
		logic ad;
		logic addrHigh;
		logic refresh;
		logic direction;
	} lbc_oe_t;

endpackage

// ==== hw/lbc_sync.sv ====
// Multi-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module lbc_sync #(
	parameter int WIDTH  = 1,
	parameter int STAGES = lbc_pkg::SYNC_STAGES
) (
	// Clock and control
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// Levels
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	if (STAGES < 2 || WIDTH < 1)
		$error("lbc_sync needs at least two stages and one bit");

	logic [WIDTH-1:0] stage_r [STAGES];

	// Only the next stage reads a stage; metastability stays in the chain
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < STAGES; i++)
				stage_r[i] <= '0;
		end
		else if (ce)
		begin
			stage_r[0] <= asyncIn;
			for (int i = 1; i < STAGES; i++)
				stage_r[i] <= stage_r[i-1];
		end
	end

	assign syncOut = stage_r[STAGES-1];

endmodule

// ==== hw/lbc_strap.sv ====
// Reset-time capture of mode strap pins
`timescale 1ns/1ns
module lbc_strap (
	// Clock and control
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic ce,
	// Strap pins, pulled up by the pads while reset is applied
	input  wire logic readStrobeQueueStrap,
	input  wire logic upperMemorySelect,
	input  wire logic lowerMemorySelect,
	input  wire logic testInput,
	// Captured modes
	output logic      queueStatusMode,
	output logic      allPinsFloatMode,
	output logic      enhancedMode
);

	logic runPrev_r;
	logic testLowSeen_r;

	// Straps follow the pins while reset is held and freeze on release
	always_ff @(posedge clock)
	begin
		runPrev_r <= rst_n;
		if (!rst_n)
		begin
			queueStatusMode  <= !readStrobeQueueStrap;
			allPinsFloatMode <= !upperMemorySelect && !lowerMemorySelect;
			testLowSeen_r    <= (testLowSeen_r && !runPrev_r) || !testInput;
			enhancedMode     <= testLowSeen_r && testInput;
		end
		else if (ce)
		begin
			testLowSeen_r <= testLowSeen_r;
		end
	end

endmodule

// ==== dv/lbc_properties.sv ====
// Concurrent checks on the bus controller pins
`timescale 1ns/1ns
module lbc_checker (
	// Clock and control
	input wire logic               clock,
	input wire logic               rst_n,
	// Observed ports
	input wire logic               refreshReq,
	input wire logic               holdRequest,
	input wire logic               busGrantOut,
	input wire lbc_pkg::lbc_pins_t pins,
	input wire lbc_pkg::lbc_oe_t   pinsOe
);
	// ****
	// Bus cycle steps
	// ****
	default clocking @(posedge clock); endclocking
	sequence s_addr;
		pins.ale && pins.readN && pins.writeN;
	endsequence
	sequence s_data;
		!pins.ale && !(pins.readN && pins.writeN);
	endsequence

	// ****
	// Cycle properties
	// ****
	chk_ale_then_strobe: assert property (disable iff (!rst_n)
		s_addr |=> s_data) else $error("ale not followed by a strobe");
	chk_enable_in_cycle: assert property (disable iff (!rst_n)
		pinsOe.strobes && !(pins.readN && pins.writeN)
		|-> !pins.transceiverEnableN) else $error("enable high in cycle");
	chk_direction_kind: assert property (disable iff (!rst_n)
		pinsOe.strobes && !(pins.readN && pins.writeN)
		|-> pins.transceiverDirection == !pins.writeN)
		else $error("direction wrong");

	// ****
	// Reset properties
	// ****
	// No disable here: these rules speak of the reset period itself
	chk_reset_floats: assert property (!rst_n |=>
		!pins.ale && !busGrantOut && !pinsOe.ad && !pinsOe.addrHigh
		&& !pinsOe.refresh && !pinsOe.direction)
		else $error("line driven in reset");
	chk_reset_drive: assert property (rst_n ##1 !rst_n |=>
		pinsOe.strobes && pinsOe.status && pinsOe.lock && pins.readN
		&& pins.writeN && pins.transceiverEnableN && pins.lockN
		&& pins.busStatusLines == lbc_pkg::STAT_PASSIVE)
		else $error("first reset clock not driven high");
	chk_reset_release: assert property (!rst_n [*2] |=>
		!pinsOe.strobes && !pinsOe.status && !pinsOe.lock)
		else $error("strobes not floated in reset");

	// ****
	// Hold properties
	// ****
	chk_grant_floats: assert property (disable iff (!rst_n)
		busGrantOut |-> pinsOe == '0) else $error("pin driven while granted");
	chk_grant_synced: assert property (disable iff (!rst_n)
		$rose(busGrantOut) |-> $past(holdRequest, 2))
		else $error("grant before request synchronised");
	chk_grant_idle: assert property (disable iff (!rst_n)
		$rose(busGrantOut) |-> $past(pins.readN) && $past(pins.writeN))
		else $error("grant inside a cycle");
	chk_refresh_reclaim: assert property (disable iff (!rst_n)
		busGrantOut && refreshReq |-> ##[1:2] !busGrantOut)
		else $error("grant kept with refresh pending");
	chk_no_retake: assert property (disable iff (!rst_n)
		!busGrantOut && !pinsOe.strobes && holdRequest |=> !pinsOe.strobes)
		else $error("bus retaken while request held");
endmodule

bind lbc_top lbc_checker u_checker (
	.clock(clock), .rst_n(rst_n), .refreshReq(refreshReq),
	.holdRequest(holdRequest), .busGrantOut(busGrantOut),
	.pins(pins), .pinsOe(pinsOe)
);

// ==== dv/lbc_partner.sv ====
// Alternate bus master and external byte memory beside the controller
`timescale 1ns/1ns
module lbc_partner (
	// Clock
	input wire logic               clock,
	// Bench controls
	input wire logic               wantBus,
	input wire logic [3:0]         waitCycles,
	// Controller side
	input wire logic               busGrantOut,
	input wire lbc_pkg::lbc_pins_t pins,
	output logic                   holdRequest,
	output logic                   syncReadyInput,
	output logic                   asyncReadyInput,
	output logic [7:0]             adIn
);
	logic [7:0] mem [256];
	logic [7:0] addrLat_r = 8'h00;
	logic [7:0] lastRd_r  = 8'h00;
	logic [3:0] waitCnt_r = 4'hf;
	logic       granted_r = 1'b0;
	logic       backOff_r = 1'b0;
	logic       ready;

	initial
	begin
		holdRequest = 1'b0;
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'ha5;
	end

	// ****
	// Alternate master
	// ****
	// One master only: several would need an arbiter in front of this pair
	always @(posedge clock)
	begin
		granted_r <= busGrantOut;
		if (!wantBus)
			backOff_r <= 1'b0;
		else if (granted_r && !busGrantOut)
			backOff_r <= 1'b1;
		holdRequest <= wantBus && !backOff_r
			&& !(granted_r && !busGrantOut);
	end

	// ****
	// Memory and ready
	// ****
	// Odd wait counts answer on the asynchronous ready input
	// Ready only inside a strobe, so no stale level leaks into the next cycle
	assign ready = waitCnt_r >= waitCycles && !(pins.readN && pins.writeN);
	assign syncReadyInput = ready && !waitCycles[0];
	assign asyncReadyInput = ready && waitCycles[0];
	// A released bus shows the inverse of the last byte, never a stale copy
	assign adIn = pins.readN ? ~lastRd_r : mem[addrLat_r];

	always @(posedge clock)
	begin
		if (pins.ale)
			waitCnt_r <= 4'h0;
		else if (waitCnt_r != 4'hf)
			waitCnt_r <= waitCnt_r + 4'h1;
		if (pins.ale)
			addrLat_r <= pins.adOut;
		if (!pins.writeN)
			mem[addrLat_r] <= pins.adOut;
		if (!pins.readN)
			lastRd_r <= adIn;
	end
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the local bus controller
`timescale 1ns/1ns
module tb_top;
	logic               clock;
	logic               rst_n;
	logic               cpuReqValid;
	lbc_pkg::lbc_req_t  cpuReq;
	logic               refreshReq;
	logic               cpuDone;
	logic [7:0]         cpuReadData;
	logic               refreshDone;
	logic               holdRequest;
	logic               busGrantOut;
	logic               syncReadyInput;
	logic               asyncReadyInput;
	logic [7:0]         adIn;
	lbc_pkg::lbc_pins_t pins;
	lbc_pkg::lbc_oe_t   pinsOe;
	logic [3:0]         straps;
	logic [3:0]         waitCycles;
	logic               wantBus;
	logic               queueStatusMode;
	logic               allPinsFloatMode;
	logic               enhancedMode;
	logic               interruptSlaveMode;
	logic               controlBlockInMemory;
	logic               sawGrant;
	logic [7:0]         rd;
	int                 n;
	int                 fails;
	int                 num_checks;

	lbc_top DUT (
		.clock(clock), .rst_n(rst_n), .ce(1'b1),
		.cpuReqValid(cpuReqValid), .cpuReq(cpuReq),
		.refreshReq(refreshReq), .cpuDone(cpuDone),
		.cpuReadData(cpuReadData), .refreshDone(refreshDone),
		.holdRequest(holdRequest), .busGrantOut(busGrantOut),
		.syncReadyInput(syncReadyInput),
		.asyncReadyInput(asyncReadyInput), .adIn(adIn),
		.pins(pins), .pinsOe(pinsOe),
		.readStrobeQueueStrap(straps[3]), .upperMemorySelect(straps[2]),
		.lowerMemorySelect(straps[1]), .testInput(straps[0]),
		.queueStatusMode(queueStatusMode),
		.allPinsFloatMode(allPinsFloatMode), .enhancedMode(enhancedMode),
		.interruptSlaveMode(interruptSlaveMode),
		.controlBlockInMemory(controlBlockInMemory)
	);

	lbc_partner u_partner (
		.clock(clock), .wantBus(wantBus), .waitCycles(waitCycles),
		.busGrantOut(busGrantOut), .pins(pins), .holdRequest(holdRequest),
		.syncReadyInput(syncReadyInput), .asyncReadyInput(asyncReadyInput),
		.adIn(adIn)
	);

	// ****
	// Clock, watchdog, grant monitor
	// ****
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	initial
	begin
		#400000;
		fails++;
		test_done();
	end

	always @(posedge clock)
		if (busGrantOut === 1'b1)
			sawGrant = 1'b1;

	// ****
	// Tasks
	// ****
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic hit(input int sel);
		case (sel)
			0: return busGrantOut === 1'b1;
			1: return refreshDone === 1'b1;
			2: return busGrantOut === 1'b0 && pinsOe.strobes === 1'b1;
			default: return cpuDone === 1'b1;
		endcase
	endfunction

	// Bounded wait; a hang counts as a mismatch
	task automatic await(input int sel);
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (!hit(sel) && n < 200);
		if (n >= 200)
			fails++;
	endtask

	task automatic bus(input lbc_pkg::lbc_kind_t k, input logic [19:0] a,
		input logic [7:0] d, input logic lk, input logic [3:0] w);
		@(posedge clock);
		#1;
		waitCycles = w;
		cpuReq = '{k, a, d, lk};
		cpuReqValid = 1'b1;
		await(3);
		rd = cpuReadData;
		#1;
		cpuReqValid = 1'b0;
	endtask

	// Strap pins idle high, as the pull-ups hold them
	task automatic do_reset(input logic [3:0] s0, input logic [3:0] s1);
		@(posedge clock);
		#1;
		rst_n = 1'b0;
		straps = s0;
		repeat (5) @(posedge clock);
		#1;
		straps = s1;
		repeat (5) @(posedge clock);
		#1;
		rst_n = 1'b1;
		straps = 4'hf;
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ****
	// Tests
	// ****
	initial
	begin
		rst_n = 1'b0;
		cpuReqValid = 1'b0;
		cpuReq = '0;
		refreshReq = 1'b0;
		wantBus = 1'b0;
		waitCycles = 4'h0;
		straps = 4'h0;
		sawGrant = 1'b0;
		fails = 0;
		num_checks = 0;
		do_reset(4'h0, 4'h7);
		check({queueStatusMode, allPinsFloatMode, enhancedMode}, 3'h5);
		bus(lbc_pkg::KIND_IORD, 20'h0fffe, 8'h00, 1'b0, 4'h0);
		check(rd, 8'hff);
		bus(lbc_pkg::KIND_IORD, 20'h0ffff, 8'h00, 1'b0, 4'h0);
		check(rd, 8'h20);
		check({interruptSlaveMode, controlBlockInMemory}, 2'h0);
		bus(lbc_pkg::KIND_MEMWR, 20'h12345, 8'h3c, 1'b0, 4'h0);
		check(16'(n), 16'd5);
		bus(lbc_pkg::KIND_MEMRD, 20'h12345, 8'h00, 1'b0, 4'h2);
		check(rd, 8'h3c);
		check(n > 5, 1'b1);
		// Move the block, then give far memory a different byte there
		bus(lbc_pkg::KIND_IOWR, 20'h0fffe, 8'h55, 1'b0, 4'h0);
		bus(lbc_pkg::KIND_MEMWR, 20'h003fe, 8'hc3, 1'b0, 4'h0);
		bus(lbc_pkg::KIND_IORD, 20'h055fe, 8'h00, 1'b0, 4'h3);
		check(rd, 8'h55);
		check(16'(n), 16'd5);
		bus(lbc_pkg::KIND_IORD, 20'h0fffe, 8'h00, 1'b0, 4'h1);
		check(rd, 8'hc3);
		bus(lbc_pkg::KIND_IOWR, 20'h055ff, 8'h50, 1'b0, 4'h0);
		check({interruptSlaveMode, controlBlockInMemory}, 2'h3);
		bus(lbc_pkg::KIND_MEMRD, 20'h055ff, 8'h00, 1'b0, 4'h2);
		check(rd, 8'h50);
		check(16'(n), 16'd5);
		bus(lbc_pkg::KIND_IORD, 20'h055fe, 8'h00, 1'b0, 4'h2);
		check(n > 5, 1'b1);
		bus(lbc_pkg::KIND_MEMRD, 20'h05500, 8'h00, 1'b0, 4'h0);
		check(rd, 8'h00);
		// Hold, then a refresh takes the bus back
		wantBus = 1'b1;
		await(0);
		check(pinsOe, 7'h00);
		#1;
		refreshReq = 1'b1;
		@(posedge clock);
		#1;
		refreshReq = 1'b0;
		await(1);
		check(refreshDone, 1'b1);
		#1;
		wantBus = 1'b0;
		await(2);
		// Refresh outranks a hold that is synchronised in the same cycle
		@(posedge clock);
		#1;
		wantBus = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		refreshReq = 1'b1;
		@(posedge clock);
		#1;
		refreshReq = 1'b0;
		sawGrant = 1'b0;
		await(1);
		check(sawGrant, 1'b0);
		await(0);
		check(busGrantOut, 1'b1);
		#1;
		wantBus = 1'b0;
		await(2);
		// A hold arriving in a locked cycle waits for the unlocked one
		sawGrant = 1'b0;
		fork
			begin
				bus(lbc_pkg::KIND_MEMWR, 20'h00010, 8'h11, 1'b1, 4'h3);
				bus(lbc_pkg::KIND_MEMWR, 20'h00011, 8'h22, 1'b0, 4'h0);
			end
			begin
				repeat (4) @(posedge clock);
				#1;
				wantBus = 1'b1;
			end
		join
		check(sawGrant, 1'b0);
		await(0);
		check(busGrantOut, 1'b1);
		#1;
		wantBus = 1'b0;
		await(2);
		do_reset(4'h9, 4'h9);
		check({queueStatusMode, allPinsFloatMode, enhancedMode}, 3'h2);
		bus(lbc_pkg::KIND_IORD, 20'h0fffe, 8'h00, 1'b0, 4'h0);
		check(rd, 8'hff);
		check(pinsOe, 7'h00);
		test_done();
	end
endmodule
